// >>> shared/wdg_pkg.sv
package wdg_pkg;

    // ****************************************
    // Clocks and timing
    // ****************************************
    localparam int WDG_CLK_FREQ_HZ = 40000000;
    localparam int WDG_OSC_FREQ_HZ = 128000;
    localparam int WDG_CE_WINDOW_CYC = 4;
    localparam logic [2:0] WDG_CE_LAST = 3'(WDG_CE_WINDOW_CYC - 1);
    localparam logic [20:0] WDG_BASE_TIMEOUT_OSC = 21'h000800;
    localparam logic [3:0] WDG_MAX_PRESC_CODE = 4'h9;

    // ****************************************
    // Register select and field layout
    // ****************************************
    localparam logic WDG_SEL_FLAGS = 1'b0;
    localparam logic WDG_SEL_CTRL = 1'b1;

    localparam int WDG_CTRL_IRQ_FLAG = 7;
    localparam int WDG_CTRL_IRQ_EN = 6;
    localparam int WDG_CTRL_PRESC3 = 5;
    localparam int WDG_CTRL_CHG_EN = 4;
    localparam int WDG_CTRL_RST_EN = 3;
    localparam int WDG_CTRL_PRESC_LO = 0;

    localparam int WDG_FLAG_WDT = 3;
    localparam int WDG_FLAG_BOD = 2;
    localparam int WDG_FLAG_EXT = 1;
    localparam int WDG_FLAG_POR = 0;

    localparam logic [3:0] WDG_FLAGS_RESET = 4'h1;
    localparam logic [3:0] WDG_PRESC_RESET = 4'h0;

    // ****************************************
    // Core command opcodes
    // ****************************************
    localparam logic [1:0] WDG_OP_WRITE = 2'h0;
    localparam logic [1:0] WDG_OP_READ = 2'h1;
    localparam logic [1:0] WDG_OP_RESTART = 2'h2;
    localparam logic [1:0] WDG_OP_VECTOR = 2'h3;

    typedef enum logic [3:0] {
        WDG_MODE_STOP = 4'h1,
        WDG_MODE_IRQ = 4'h2,
        WDG_MODE_RST = 4'h4,
        WDG_MODE_COMBO = 4'h8
    } wdg_mode_t;

    typedef enum logic [2:0] {
        WDG_CPU_IDLE = 3'h1,
        WDG_CPU_ISSUE = 3'h2,
        WDG_CPU_WAIT = 3'h4
    } wdg_cpu_state_t;

endpackage

// >>> shared/wdg_link_if.sv
`timescale 1ns/1ps
interface wdg_link_if;
    logic regWr;
    logic regRd;
    logic regSel;
    logic [7:0] wrData;
    logic restart;
    logic vectorAck;
    logic [7:0] rdData;
    logic timeoutIrq;
    logic wdtResetPulse;

    modport dev (
        input regWr,
        input regRd,
        input regSel,
        input wrData,
        input restart,
        input vectorAck,
        output rdData,
        output timeoutIrq,
        output wdtResetPulse
    );

    modport cpu (
        output regWr,
        output regRd,
        output regSel,
        output wrData,
        output restart,
        output vectorAck,
        input rdData,
        input timeoutIrq,
        input wdtResetPulse
    );
endinterface

// >>> verilog/wdg_device.sv
// Operation
// [R1] Watchdog reset is one-cycle pulse
// [R2] Cause flags bits 7..4 read zero
// [R3] Watchdog flag set on watchdog reset
// [R4] Brown-out flag set on brown-out event
// [R5] External flag set on external reset
// [R6] Power-on flag cleared only by software
// [R7] Software reads then clears flags early
// [R8] Counter counts 128 kHz oscillator cycles
// [R9] Restart clears counter before time-out
// [R10] Interrupt mode raises wake-capable interrupt
// [R11] Reset mode resets on expiry
// [R12] Combined mode: interrupt, then reset
// [R13] Fuse forces reset mode, locks bits
// [R14] Clear enable or prescaler needs sequence
// [R15] Open sequence: change and reset-enable one
// [R16] Within four cycles write new settings
// [R17] Time-outs from 16 ms to 8 s
// [R18] Watchdog stays enabled after its reset
// [R19] Init firmware clears flag and enable
// [R20] Watchdog flag holds reset-enable at one
// [R21] Change-enable self-clears after four cycles
// [R22] Prescaler doubles 2048 to 1048576 cycles
// [R23] Time-out sets flag; vector clears it
`timescale 1ns/1ps
module wdg_device
    import wdg_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    wdg_link_if.dev link,
    input wire logic osc128k,
    input wire logic brownoutIn,
    input wire logic extResetIn,
    input wire logic alwaysOnFuse,
    output logic sysResetPulse,
    output logic wakeIrq
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [1:0] oscSync;
        logic [1:0] bodSync;
        logic [1:0] extSync;
        logic [1:0] fuseSync;
        logic oscPrev;
        logic bodPrev;
        logic extPrev;
        logic [19:0] count;
        logic irqFlag;
        logic irqEn;
        logic chgEn;
        logic [2:0] chgCnt;
        logic rstEn;
        logic [3:0] presc;
        logic [3:0] causeFlags;
        logic [7:0] rdData;
        logic irqOut;
        logic rstPulse;
    } wdg_dev_state_t;

    wdg_dev_state_t state_r;
    wdg_dev_state_t state_nxt;

    logic oscTick;
    logic bodEvt;
    logic extEvt;
    logic fuseOn;
    logic wdeEff;
    logic ieEff;
    logic running;
    logic timeout;
    logic wdtFire;
    logic [3:0] prescSat;
    logic [20:0] limit;
    logic [7:0] ctrlView;
    wdg_mode_t mode;
    logic wrCe;
    logic wrWde;
    logic [3:0] wrPresc;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        state_nxt = state_r;

        // Pins pass two flops; only the second stage feeds logic
        state_nxt.oscSync = {state_r.oscSync[0], osc128k};
        state_nxt.bodSync = {state_r.bodSync[0], brownoutIn};
        state_nxt.extSync = {state_r.extSync[0], extResetIn};
        state_nxt.fuseSync = {state_r.fuseSync[0], alwaysOnFuse};
        state_nxt.oscPrev = state_r.oscSync[1];
        state_nxt.bodPrev = state_r.bodSync[1];
        state_nxt.extPrev = state_r.extSync[1];

        oscTick = state_r.oscSync[1] & ~state_r.oscPrev; // [R8]
        bodEvt = state_r.bodSync[1] & ~state_r.bodPrev;
        extEvt = state_r.extSync[1] & ~state_r.extPrev;
        fuseOn = state_r.fuseSync[1];

        wdeEff = state_r.rstEn | state_r.causeFlags[WDG_FLAG_WDT] | fuseOn; // [R13] [R20]
        ieEff = state_r.irqEn & ~fuseOn; // [R13]

        case ({wdeEff, ieEff})
            2'b01: mode = WDG_MODE_IRQ;
            2'b10: mode = WDG_MODE_RST;
            2'b11: mode = WDG_MODE_COMBO;
            default: mode = WDG_MODE_STOP;
        endcase
        running = (mode != WDG_MODE_STOP);

        // Reserved codes run at the longest period rather than wrapping short
        prescSat = (state_r.presc > WDG_MAX_PRESC_CODE) ? WDG_MAX_PRESC_CODE : state_r.presc;
        limit = WDG_BASE_TIMEOUT_OSC << prescSat; // [R17] [R22]
        // Compare by >= so a shorter period picked mid-count still expires
        timeout = running && oscTick && ({1'b0, state_r.count} >= (limit - 21'h000001));

        // ****************************************
        // Counter
        // ****************************************
        if (!running || link.restart || timeout) begin
            state_nxt.count = 20'h00000; // [R9]
        end else if (oscTick) begin
            state_nxt.count = state_r.count + 20'h00001;
        end

        // ****************************************
        // Change-enable window
        // ****************************************
        if (state_r.chgEn) begin
            state_nxt.chgCnt = state_r.chgCnt + 3'h1;
            if (state_r.chgCnt == WDG_CE_LAST) begin
                state_nxt.chgEn = 1'b0; // [R21]
            end
        end

        // ****************************************
        // Register writes
        // ****************************************
        wrCe = link.wrData[WDG_CTRL_CHG_EN];
        wrWde = link.wrData[WDG_CTRL_RST_EN];
        wrPresc = {link.wrData[WDG_CTRL_PRESC3], link.wrData[WDG_CTRL_PRESC_LO +: 3]};

        if (link.regWr && link.regSel == WDG_SEL_CTRL) begin
            if (link.wrData[WDG_CTRL_IRQ_FLAG]) begin
                state_nxt.irqFlag = 1'b0; // [R23]
            end
            state_nxt.irqEn = link.wrData[WDG_CTRL_IRQ_EN];
            if (wrCe && wrWde) begin
                // Opening write also sets the enable, never clears it
                state_nxt.chgEn = 1'b1; // [R15]
                state_nxt.chgCnt = 3'h0;
                state_nxt.rstEn = 1'b1;
            end else if (state_r.chgEn && !wrCe) begin
                state_nxt.rstEn = wrWde; // [R14] [R16]
                state_nxt.presc = wrPresc;
                state_nxt.chgEn = 1'b0;
            end else if (wrWde) begin
                // Outside the window only setting the enable takes effect
                state_nxt.rstEn = 1'b1; // [R14]
            end
        end

        if (link.regWr && link.regSel == WDG_SEL_FLAGS) begin
            // Writing zero clears; writing one leaves the flag as it was
            state_nxt.causeFlags = state_r.causeFlags & link.wrData[3:0]; // [R3] [R4] [R5] [R6]
        end

        if (link.vectorAck) begin
            state_nxt.irqFlag = 1'b0; // [R23]
            if (wdeEff) begin
                state_nxt.irqEn = 1'b0; // [R12] [R23]
            end
        end

        // ****************************************
        // Time-out actions; they win over clears
        // ****************************************
        wdtFire = 1'b0;
        if (timeout) begin
            case (mode)
                WDG_MODE_IRQ: state_nxt.irqFlag = 1'b1; // [R10] [R23]
                WDG_MODE_RST: wdtFire = 1'b1; // [R11]
                WDG_MODE_COMBO: begin
                    // A pending unserviced interrupt means the first expiry passed
                    if (state_r.irqFlag) begin
                        wdtFire = 1'b1; // [R12]
                    end else begin
                        state_nxt.irqFlag = 1'b1; // [R12]
                    end
                end
                default: wdtFire = 1'b0;
            endcase
        end
        state_nxt.rstPulse = wdtFire; // [R1]

        // ****************************************
        // Reset causes
        // ****************************************
        if (wdtFire || bodEvt || extEvt) begin
            // System reset clears the control register, not the cause flags
            state_nxt.irqFlag = 1'b0;
            state_nxt.irqEn = 1'b0;
            state_nxt.chgEn = 1'b0;
            state_nxt.chgCnt = 3'h0;
            state_nxt.rstEn = 1'b0;
            state_nxt.presc = WDG_PRESC_RESET;
            state_nxt.count = 20'h00000;
        end
        if (wdtFire) begin
            // Flag keeps the effective enable high, so the dog keeps biting
            state_nxt.causeFlags[WDG_FLAG_WDT] = 1'b1; // [R3] [R18]
        end
        if (bodEvt) begin
            state_nxt.causeFlags[WDG_FLAG_BOD] = 1'b1; // [R4]
        end
        if (extEvt) begin
            state_nxt.causeFlags[WDG_FLAG_EXT] = 1'b1; // [R5]
        end

        // ****************************************
        // Read data and outputs
        // ****************************************
        ctrlView = 8'h00;
        ctrlView[WDG_CTRL_IRQ_FLAG] = state_r.irqFlag;
        ctrlView[WDG_CTRL_IRQ_EN] = ieEff;
        ctrlView[WDG_CTRL_PRESC3] = state_r.presc[3];
        ctrlView[WDG_CTRL_CHG_EN] = state_r.chgEn;
        ctrlView[WDG_CTRL_RST_EN] = wdeEff;
        ctrlView[WDG_CTRL_PRESC_LO +: 3] = state_r.presc[2:0];
        if (link.regRd) begin
            if (link.regSel == WDG_SEL_CTRL) begin
                state_nxt.rdData = ctrlView;
            end else begin
                state_nxt.rdData = {4'h0, state_r.causeFlags}; // [R2]
            end
        end

        // Level request; it also serves as the wake-up source in sleep
        state_nxt.irqOut = state_nxt.irqFlag & state_nxt.irqEn & ~fuseOn; // [R10]
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // sys_rst is the power-on reset; it is the only thing that sets that flag
            state_r <= '0;
            state_r.causeFlags <= WDG_FLAGS_RESET; // [R6]
        end else begin
            state_r <= state_nxt;
        end
    end

    assign link.rdData = state_r.rdData;
    assign link.timeoutIrq = state_r.irqOut;
    assign link.wdtResetPulse = state_r.rstPulse;
    assign sysResetPulse = state_r.rstPulse;
    assign wakeIrq = state_r.irqOut;

endmodule

// >>> verilog/wdg_cpu.sv
`timescale 1ns/1ps
module wdg_cpu
    import wdg_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    wdg_link_if.cpu link,
    input wire logic cmdValid,
    input wire logic [1:0] cmdOp,
    input wire logic cmdSel,
    input wire logic [7:0] cmdData,
    output logic cmdReady,
    output logic rspValid,
    output logic [7:0] rspData,
    output logic irqSeen,
    output logic resetSeen
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        wdg_cpu_state_t fsm;
        logic cmdReady;
        logic regWr;
        logic regRd;
        logic regSel;
        logic [7:0] wrData;
        logic restart;
        logic vectorAck;
        logic rspValid;
        logic [7:0] rspData;
        logic irqSeen;
        logic resetSeen;
    } wdg_cpu_reg_t;

    wdg_cpu_reg_t state_r;
    wdg_cpu_reg_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        state_nxt.regWr = 1'b0;
        state_nxt.regRd = 1'b0;
        state_nxt.restart = 1'b0;
        state_nxt.vectorAck = 1'b0;
        state_nxt.rspValid = 1'b0;
        state_nxt.irqSeen = link.timeoutIrq;
        state_nxt.resetSeen = link.wdtResetPulse;
        case (state_r.fsm)
            WDG_CPU_IDLE: begin
                if (cmdValid) begin
                    // One access per command keeps the timed sequence in one write each
                    state_nxt.regSel = cmdSel;
                    state_nxt.wrData = cmdData;
                    state_nxt.regWr = (cmdOp == WDG_OP_WRITE); // [R15] [R16]
                    state_nxt.regRd = (cmdOp == WDG_OP_READ);
                    state_nxt.restart = (cmdOp == WDG_OP_RESTART); // [R9]
                    state_nxt.vectorAck = (cmdOp == WDG_OP_VECTOR);
                    state_nxt.cmdReady = 1'b0;
                    state_nxt.fsm = WDG_CPU_ISSUE;
                end
            end
            WDG_CPU_ISSUE: begin
                if (state_r.regRd) begin
                    state_nxt.fsm = WDG_CPU_WAIT;
                end else begin
                    state_nxt.cmdReady = 1'b1;
                    state_nxt.fsm = WDG_CPU_IDLE;
                end
            end
            WDG_CPU_WAIT: begin
                state_nxt.rspValid = 1'b1;
                state_nxt.rspData = link.rdData;
                state_nxt.cmdReady = 1'b1;
                state_nxt.fsm = WDG_CPU_IDLE;
            end
            default: begin
                state_nxt.cmdReady = 1'b1;
                state_nxt.fsm = WDG_CPU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= '0;
            state_r.fsm <= WDG_CPU_IDLE;
            state_r.cmdReady <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign link.regWr = state_r.regWr;
    assign link.regRd = state_r.regRd;
    assign link.regSel = state_r.regSel;
    assign link.wrData = state_r.wrData;
    assign link.restart = state_r.restart;
    assign link.vectorAck = state_r.vectorAck;
    assign cmdReady = state_r.cmdReady;
    assign rspValid = state_r.rspValid;
    assign rspData = state_r.rspData;
    assign irqSeen = state_r.irqSeen;
    assign resetSeen = state_r.resetSeen;

endmodule

// >>> tb/wdg_link_props.sv
`timescale 1ns/1ps
module wdg_link_props
    import wdg_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic regSel,
    input wire logic [7:0] wrData,
    input wire logic restart,
    input wire logic vectorAck,
    input wire logic [7:0] rdData,
    input wire logic timeoutIrq,
    input wire logic wdtResetPulse
);
    // ****
    // Shadow of power-on and watchdog flags and window age
    // ****
    logic porSeen;
    logic wdtSeen;
    logic [3:0] sinceOpen;
    logic flagWr;
    logic ctlRd;
    logic flgRd;
    assign flagWr = regWr && regSel == WDG_SEL_FLAGS;
    assign ctlRd = regRd && regSel == WDG_SEL_CTRL;
    assign flgRd = regRd && regSel == WDG_SEL_FLAGS;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            porSeen <= 1'b1;
            wdtSeen <= 1'b0;
            sinceOpen <= 4'hf;
        end else begin
            if (flagWr && !wrData[0]) porSeen <= 1'b0;
            if (wdtResetPulse) wdtSeen <= 1'b1;
            else if (flagWr && !wrData[3]) wdtSeen <= 1'b0;
            if (regWr && regSel && wrData[4] && wrData[3]) sinceOpen <= 4'h0;
            else if (sinceOpen != 4'hf) sinceOpen <= sinceOpen + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_RSVD_ZERO: assert property (flgRd |=> rdData[7:4] == 4'h0)
        else $error("reserved flag bits not zero");
    AST_POR_KEPT: assert property (flgRd |=> rdData[0] == $past(porSeen))
        else $error("power-on flag wrong");
    AST_WDT_FLAG: assert property (flgRd && wdtSeen |=> rdData[3])
        else $error("watchdog flag not set");
    AST_RSTEN_HELD: assert property (ctlRd && wdtSeen |=> rdData[3])
        else $error("reset enable not held");
    // Window is high for four cycles after the opening write lands
    AST_CHG_CLOSED: assert property (ctlRd && sinceOpen > 4'h3 |=> !rdData[4])
        else $error("change enable not cleared");
    AST_PULSE_ONE: assert property (wdtResetPulse |=> !wdtResetPulse)
        else $error("reset pulse longer than one cycle");
    AST_RST_CLEARS: assert property (wdtResetPulse |-> ##[1:2] !timeoutIrq)
        else $error("irq survives watchdog reset");
    AST_VECTOR_CLR: assert property (vectorAck |-> ##[1:2] !timeoutIrq)
        else $error("vector did not clear irq");
    AST_W1C: assert property (regWr && regSel && wrData[7] |-> ##[1:2] !timeoutIrq)
        else $error("flag write did not clear irq");
    AST_RESTART: assert property (restart |-> ##2
        (!wdtResetPulse && !$rose(timeoutIrq)) [*8])
        else $error("expiry right after restart");
    cover property (wdtResetPulse);
    cover property ($rose(timeoutIrq));
    cover property (vectorAck);
    cover property (ctlRd && wdtSeen);
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
    import wdg_pkg::*;
;
    logic clk = 0, sys_rst = 1, osc128k = 0, brownoutIn = 0, extResetIn = 0;
    logic alwaysOnFuse = 0, cmdValid = 0, cmdSel = 0, cmdReady, rspValid;
    logic [1:0] cmdOp = 2'h0;
    logic [7:0] cmdData = 8'h00, rspData, r;
    logic sysResetPulse, wakeIrq, irqSeen, resetSeen, oscRun = 0;
    int num_errors = 0, compares = 0, cyc = 0, takeCyc, openCyc = -100, n;
    int mFlags = 1, mIrqFlag = 0, mIrqEn = 0, mRstEn = 0, mPresc = 0, fuseOn = 0;
    logic [3:0] p;
    wdg_link_if linkIf();
    wdg_device wdg_device_inst (.clk(clk), .sys_rst(sys_rst), .link(linkIf),
        .osc128k(osc128k), .brownoutIn(brownoutIn), .extResetIn(extResetIn),
        .alwaysOnFuse(alwaysOnFuse), .sysResetPulse(sysResetPulse), .wakeIrq(wakeIrq));
    wdg_cpu wdg_cpu_inst (.clk(clk), .sys_rst(sys_rst), .link(linkIf), .cmdValid(cmdValid),
        .cmdOp(cmdOp), .cmdSel(cmdSel), .cmdData(cmdData), .cmdReady(cmdReady),
        .rspValid(rspValid), .rspData(rspData), .irqSeen(irqSeen), .resetSeen(resetSeen));
    wdg_link_props wdg_link_props_inst (.clk(clk), .sys_rst(sys_rst),
        .regWr(linkIf.regWr), .regRd(linkIf.regRd), .regSel(linkIf.regSel),
        .wrData(linkIf.wrData), .restart(linkIf.restart), .vectorAck(linkIf.vectorAck),
        .rdData(linkIf.rdData), .timeoutIrq(linkIf.timeoutIrq),
        .wdtResetPulse(linkIf.wdtResetPulse));
    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // Oscillator rises every 4 clocks so the synchroniser sees every edge
    always @(negedge clk) if (oscRun && cyc[0]) osc128k <= ~osc128k;
    // ****
    // Command tasks and reference model
    // ****
    task automatic conclude();
        if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmd(input logic [1:0] op, input logic sel, input logic [7:0] d);
        int k;
        while (cmdReady !== 1'b1) @(negedge clk);
        takeCyc = cyc;
        cmdValid = 1'b1;
        cmdOp = op;
        cmdSel = sel;
        cmdData = d;
        @(negedge clk);
        cmdValid = 1'b0;
        k = 0;
        while (op == WDG_OP_READ && rspValid !== 1'b1 && k < 8) begin
            @(negedge clk);
            k++;
        end
        if (op == WDG_OP_READ && rspValid !== 1'b1) num_errors++;
        r = rspData;
    endtask
    function automatic logic [7:0] expCtrl();
        int eff;
        eff = mRstEn | ((mFlags >> 3) & 1) | fuseOn;
        return 8'((mIrqFlag << 7) | ((mIrqEn & ~fuseOn & 1) << 6) | ((mPresc & 8) << 2)
            | (eff << 3) | (mPresc & 7));
    endfunction
    task automatic rdChk(input logic sel);
        cmd(WDG_OP_READ, sel, 8'h00);
        `CHK(r, sel ? expCtrl() : 8'(mFlags))
    endtask
    task automatic clearCtrl(input int cause);
        mFlags |= cause;
        mIrqFlag = 0;
        mIrqEn = 0;
        mRstEn = 0;
        mPresc = 0;
        openCyc = -100;
    endtask
    task automatic wr(input logic sel, input logic [7:0] d);
        cmd(WDG_OP_WRITE, sel, d);
        if (!sel) mFlags &= d[3:0];
        else begin
            if (d[7]) mIrqFlag = 0;
            mIrqEn = d[6];
            if (takeCyc - openCyc <= WDG_CE_WINDOW_CYC && !d[4]) begin
                mRstEn = d[3];
                mPresc = {d[5], d[2:0]};
                openCyc = -100;
            end else if (d[4] && d[3]) begin
                mRstEn = 1;
                openCyc = takeCyc;
            end else if (d[3]) mRstEn = 1;
        end
    endtask
    task automatic pin(input bit ext);
        if (ext) extResetIn = 1'b1;
        else brownoutIn = 1'b1;
        repeat (4) @(negedge clk);
        extResetIn = 1'b0;
        brownoutIn = 1'b0;
        repeat (6) @(negedge clk);
        clearCtrl(ext ? 2 : 4);
    endtask
    task automatic waitFor(input bit rst);
        n = 0;
        while (((rst ? sysResetPulse : wakeIrq) !== 1'b1) && n < 12000) begin
            @(negedge clk);
            n++;
        end
    endtask
    initial begin
        // The scenarios need about 50000 cycles; this leaves ample margin
        #(25ns * 80000);
        num_errors++;
        conclude();
    end
    initial begin
        void'($urandom(58912));
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk);
        rdChk(WDG_SEL_FLAGS);
        wr(WDG_SEL_FLAGS, 8'($urandom));
        rdChk(WDG_SEL_FLAGS);
        wr(WDG_SEL_FLAGS, 8'h00);
        rdChk(WDG_SEL_FLAGS);
        pin(0);
        rdChk(WDG_SEL_FLAGS);
        pin(1);
        rdChk(WDG_SEL_FLAGS);
        wr(WDG_SEL_FLAGS, 8'h00);
        wr(WDG_SEL_CTRL, 8'h0d);
        rdChk(WDG_SEL_CTRL);
        wr(WDG_SEL_CTRL, 8'h00);
        rdChk(WDG_SEL_CTRL);
        wr(WDG_SEL_CTRL, 8'h18);
        cmd(WDG_OP_RESTART, 1'b0, 8'h00);
        // Two idle cycles push the next write one cycle past the window
        repeat (2) @(negedge clk);
        wr(WDG_SEL_CTRL, 8'h00);
        rdChk(WDG_SEL_CTRL);
        p = 4'($urandom_range(0, 15));
        wr(WDG_SEL_CTRL, 8'h18);
        wr(WDG_SEL_CTRL, {2'b00, p[3], 2'b00, p[2:0]});
        rdChk(WDG_SEL_CTRL);
        wr(WDG_SEL_CTRL, 8'h18);
        wr(WDG_SEL_CTRL, 8'h40);
        rdChk(WDG_SEL_CTRL);
        oscRun = 1'b1;
        cmd(WDG_OP_RESTART, 1'b0, 8'h00);
        repeat (4000) @(negedge clk);
        cmd(WDG_OP_RESTART, 1'b0, 8'h00);
        waitFor(0);
        `CHK(n >= 8170 && n <= 8230, 1'b1)
        mIrqFlag = 1;
        @(negedge clk);
        `CHK(irqSeen, 1'b1)
        rdChk(WDG_SEL_CTRL);
        wr(WDG_SEL_CTRL, 8'hc0);
        rdChk(WDG_SEL_CTRL);
        wr(WDG_SEL_CTRL, 8'h48);
        cmd(WDG_OP_RESTART, 1'b0, 8'h00);
        waitFor(0);
        mIrqFlag = 1;
        cmd(WDG_OP_VECTOR, 1'b0, 8'h00);
        mIrqFlag = 0;
        mIrqEn = 0;
        rdChk(WDG_SEL_CTRL);
        waitFor(1);
        `CHK(n < 8240, 1'b1)
        @(negedge clk);
        `CHK({resetSeen, sysResetPulse}, 2'b10)
        clearCtrl(8);
        rdChk(WDG_SEL_FLAGS);
        rdChk(WDG_SEL_CTRL);
        wr(WDG_SEL_CTRL, 8'h18);
        wr(WDG_SEL_CTRL, 8'h00);
        rdChk(WDG_SEL_CTRL);
        wr(WDG_SEL_FLAGS, 8'hf7);
        rdChk(WDG_SEL_CTRL);
        waitFor(1);
        `CHK(n, 12000)
        alwaysOnFuse = 1'b1;
        fuseOn = 1;
        repeat (4) @(negedge clk);
        wr(WDG_SEL_CTRL, 8'h40);
        rdChk(WDG_SEL_CTRL);
        cmd(WDG_OP_RESTART, 1'b0, 8'h00);
        waitFor(1);
        `CHK(n >= 8170 && n <= 8230, 1'b1)
        conclude();
    end
endmodule
